// >>> src/reset_seq_pkg.sv
// Constants and types shared by the reset sequencer
package reset_seq_pkg;
   localparam int STATES_PER_CYCLE = 6;
   localparam int PHASES_PER_STATE = 2;
   localparam int SLOT_BITS = 4;
   // Slot index = (state-1)*2 + (phase-1)
   localparam logic [3:0] SLOT_S5P1 = 4'h8;
   localparam logic [3:0] SLOT_S5P2 = 4'h9;
   localparam logic [3:0] SLOT_LAST = 4'hB;
   localparam int MIN_RESET_CYCLES = 2;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] IEN_RESET = 8'h00;
   localparam logic [7:0] PORT_RESET = 8'hFF;
   localparam int ARITH_CLR_BIT = 7;
   localparam int PTR_SEL_WIDTH = 3;
   localparam logic [2:0] PTR_SEL_RESET = 3'h0;
   localparam logic [7:0] WDT_RELOAD_RESET = 8'h00;
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] DPTR_RESET = 16'h0000;
   localparam int NUM_PORTS = 7;
   localparam int NUM_COMPARE = 8;
   localparam int NUM_POINTERS = 8;
   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_DETECT = 4'b0010,
      ST_HOLD = 4'b0100,
      ST_START = 4'b1000
   } seq_state_t;
endpackage

// >>> src/reset_timing_if.sv
// Machine-cycle timing signals between timebase and sequencer
`timescale 1ns/1ps
interface reset_timing_if;
   import reset_seq_pkg::*;
   logic [SLOT_BITS-1:0] slot;
   logic s5p1;
   logic s5p2;
   logic cycle_end;
   modport gen (output slot, output s5p1, output s5p2, output cycle_end);
   modport use_side (input slot, input s5p1, input s5p2, input cycle_end);
endinterface

// >>> src/machine_timebase.sv
// Twelve-phase machine cycle timebase, one phase per clock
`timescale 1ns/1ps
module machine_timebase
   import reset_seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   reset_timing_if.gen tim
);
   logic [SLOT_BITS-1:0] slot_q, slot_d;

   always_comb begin
      slot_d = (slot_q == SLOT_LAST) ? '0 : slot_q + 4'h1;
   end

   // Timebase is held at S5P1 by rst_b only, so it keeps running and sampling through pin and watchdog resets
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         slot_q <= SLOT_S5P1;
      end else begin
         slot_q <= slot_d;
      end
   end

   assign tim.slot = slot_q;
   assign tim.s5p1 = (slot_q == SLOT_S5P1);
   assign tim.s5p2 = (slot_q == SLOT_S5P2);
   assign tim.cycle_end = (slot_q == SLOT_LAST);
endmodule

// >>> src/reset_sync_and_output.sv
// Reset sequencer: pin sampling, reset hold, release timing, reset output
`timescale 1ns/1ps
module reset_sync_and_output
   import reset_seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic reset_pin_n,
   input wire logic wdt_reset_req,
   input wire logic osc_wdt_reset_req,
   input wire logic ext_program_select_n,
   output logic core_reset,
   output logic reset_out_n,
   output logic addr_drive,
   output logic ale_first_fall,
   output logic [15:0] program_counter,
   output logic [7:0] irq_enable_0,
   output logic [7:0] irq_enable_1,
   output logic [NUM_PORTS*8-1:0] port_latches,
   output logic arith_control_msb,
   output logic [PTR_SEL_WIDTH-1:0] pointer_select,
   output logic [7:0] watchdog_reload,
   output logic [7:0] stack_pointer,
   output logic [NUM_COMPARE*8-1:0] compare_low_bytes,
   output logic [NUM_POINTERS*16-1:0] data_pointers,
   output logic [7:0] b_register,
   output logic [7:0] power_control,
   output logic [7:0] program_status_word,
   output logic [7:0] timer_control
);
   reset_timing_if tim ();

   machine_timebase u_timebase (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .tim(tim.gen)
   );

   seq_state_t state_q, state_d;
   logic pin_smp_q, pin_smp_d;
   logic int_rst_q, int_rst_d;
   logic wd_req_q, wd_req_d;
   logic [1:0] wd_cnt_q, wd_cnt_d;
   logic [5:0] wd_len_q, wd_len_d;
   logic addr_q, addr_d;
   logic ale_q, ale_d;

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      pin_smp_d = pin_smp_q;
      int_rst_d = int_rst_q;
      addr_d = addr_q;
      ale_d = 1'b0;
      if (tim.s5p2) begin
         pin_smp_d = reset_pin_n;
      end
      unique case (state_q)
         ST_RUN: begin
            if (tim.s5p2 && !reset_pin_n) begin
               state_d = ST_DETECT;
            end
         end
         ST_DETECT: begin
            // Second low sample starts the forcing of defaults
            if (tim.s5p2) begin
               if (!reset_pin_n) begin
                  state_d = ST_HOLD;
                  int_rst_d = 1'b1;
                  addr_d = 1'b0;
               end else begin
                  state_d = ST_RUN;
               end
            end
         end
         ST_HOLD: begin
            // Held until a high sample at S5P2
            if (tim.s5p2 && reset_pin_n) begin
               state_d = ST_START;
               int_rst_d = 1'b0;
            end
         end
         ST_START: begin
            // With ext_program_select_n low, next S5P1 starts address output and S5P2 gives first ALE fall
            if (tim.s5p1) begin
               addr_d = !ext_program_select_n;
            end
            if (tim.s5p2) begin
               ale_d = !ext_program_select_n;
               // A low sample here already counts as the first of a new reset
               state_d = reset_pin_n ? ST_RUN : ST_DETECT;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q <= ST_RUN;
         pin_smp_q <= 1'b1;
         int_rst_q <= 1'b0;
         addr_q <= 1'b0;
         ale_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pin_smp_q <= pin_smp_d;
         int_rst_q <= int_rst_d;
         addr_q <= addr_d;
         ale_q <= ale_d;
      end
   end

   // Watchdog-class requests stretched to two full machine cycles
   // One extra count absorbs the partial cycle in which the request lands
   always_comb begin
      wd_req_d = wd_req_q;
      wd_cnt_d = wd_cnt_q;
      if (wdt_reset_req || osc_wdt_reset_req) begin
         wd_req_d = 1'b1;
         wd_cnt_d = 2'(MIN_RESET_CYCLES + 1);
      end else if (wd_req_q && tim.cycle_end) begin
         if (wd_cnt_q <= 2'h1) begin
            wd_req_d = 1'b0;
            wd_cnt_d = 2'h0;
         end else begin
            wd_cnt_d = wd_cnt_q - 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wd_req_q <= 1'b0;
         wd_cnt_q <= 2'h0;
      end else begin
         wd_req_q <= wd_req_d;
         wd_cnt_q <= wd_cnt_d;
      end
   end

   // Length of the current watchdog stretch, read only by the checks below
   always_comb begin
      wd_len_d = 6'h00;
      if (wd_req_q) begin
         wd_len_d = (wd_len_q == 6'h3F) ? wd_len_q : wd_len_q + 6'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wd_len_q <= 6'h00;
      end else begin
         wd_len_q <= wd_len_d;
      end
   end

   // Output low for a sampled low pin or a stretched watchdog request
   assign reset_out_n = pin_smp_q && !wd_req_q;
   assign core_reset = int_rst_q || wd_req_q;
   assign addr_drive = addr_q;
   assign ale_first_fall = ale_q;

   // Register defaults; internal RAM is deliberately not in this block
   logic [15:0] pc_q, pc_d;
   logic [7:0] ie0_q, ie0_d, ie1_q, ie1_d, sp_q, sp_d, wdr_q, wdr_d;
   logic [7:0] b_q, b_d, power_control_q, power_control_d, psw_q, psw_d, timer_control_q, timer_control_d;
   logic arc_q, arc_d;
   logic [PTR_SEL_WIDTH-1:0] dps_q, dps_d;
   logic [NUM_PORTS*8-1:0] port_q, port_d;
   logic [NUM_COMPARE*8-1:0] cml_q, cml_d;
   logic [NUM_POINTERS*16-1:0] dp_q, dp_d;

   always_comb begin
      {pc_d, ie0_d, ie1_d, sp_d, wdr_d} = {pc_q, ie0_q, ie1_q, sp_q, wdr_q};
      {b_d, power_control_d, psw_d, timer_control_d, arc_d, dps_d} = {b_q, power_control_q, psw_q, timer_control_q, arc_q, dps_q};
      {port_d, cml_d, dp_d} = {port_q, cml_q, dp_q};
      if (core_reset) begin
         pc_d = PC_RESET;
         ie0_d = IEN_RESET;
         ie1_d = IEN_RESET;
         port_d = {NUM_PORTS{PORT_RESET}};
         arc_d = 1'b0;
         dps_d = PTR_SEL_RESET;
         wdr_d = WDT_RELOAD_RESET;
         sp_d = SP_RESET;
         cml_d = {NUM_COMPARE{ZERO_BYTE}};
         b_d = ZERO_BYTE;
         power_control_d = ZERO_BYTE;
         psw_d = ZERO_BYTE;
         timer_control_d = ZERO_BYTE;
         dp_d = {NUM_POINTERS{DPTR_RESET}};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pc_q <= PC_RESET;
         {ie0_q, ie1_q, wdr_q, b_q, power_control_q, psw_q, timer_control_q} <= '0;
         sp_q <= SP_RESET;
         arc_q <= 1'b0;
         dps_q <= PTR_SEL_RESET;
         port_q <= {NUM_PORTS{PORT_RESET}};
         cml_q <= '0;
         dp_q <= '0;
      end else begin
         {pc_q, ie0_q, ie1_q, sp_q, wdr_q} <= {pc_d, ie0_d, ie1_d, sp_d, wdr_d};
         {b_q, power_control_q, psw_q, timer_control_q, arc_q, dps_q} <= {b_d, power_control_d, psw_d, timer_control_d, arc_d, dps_d};
         {port_q, cml_q, dp_q} <= {port_d, cml_d, dp_d};
      end
   end

   assign program_counter = pc_q;
   assign irq_enable_0 = ie0_q;
   assign irq_enable_1 = ie1_q;
   assign port_latches = port_q;
   assign arith_control_msb = arc_q;
   assign pointer_select = dps_q;
   assign watchdog_reload = wdr_q;
   assign stack_pointer = sp_q;
   assign compare_low_bytes = cml_q;
   assign data_pointers = dp_q;
   assign b_register = b_q;
   assign power_control = power_control_q;
   assign program_status_word = psw_q;
   assign timer_control = timer_control_q;

   // Checks
   a_pin_sample_slot: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !tim.s5p2 |=> pin_smp_q == $past(pin_smp_q)) else $error("pin sampled off S5P2");
   a_second_low_enter: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_q == ST_DETECT && tim.s5p2 && !reset_pin_n) |=> int_rst_q) else $error("reset not entered");
   a_hold_while_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (int_rst_q && !(tim.s5p2 && reset_pin_n)) |=> int_rst_q) else $error("reset left early");
   a_release_on_sample: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_q == ST_HOLD && tim.s5p2 && reset_pin_n) |=> !int_rst_q ##0 state_q == ST_START)
      else $error("release missed");
   a_addr_then_ale: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state_q == ST_START && tim.s5p1 && !ext_program_select_n) |=> addr_q ##1 ale_q)
      else $error("address/ALE order wrong");
   a_ext_out_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (tim.s5p2 && !wd_req_q && !wdt_reset_req && !osc_wdt_reset_req) |=> reset_out_n == $past(reset_pin_n))
      else $error("output not following pin");
   a_wd_min_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $fell(wd_req_q) |-> wd_len_q >= MIN_RESET_CYCLES * STATES_PER_CYCLE * PHASES_PER_STATE)
      else $error("watchdog reset too short");
   a_port_defaults: assert property (@(posedge sys_clk) disable iff (!rst_b)
      core_reset |=> port_latches == {NUM_PORTS{PORT_RESET}} && stack_pointer == SP_RESET
      && program_counter == PC_RESET) else $error("defaults not forced");
   a_out_any_source: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wdt_reset_req || osc_wdt_reset_req) |=> !reset_out_n) else $error("source not ORed");
   c_ext_reset: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(int_rst_q));
   c_release: cover property (@(posedge sys_clk) disable iff (!rst_b) ale_q);
   c_wdt: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(wd_req_q));
endmodule

// >>> tb/reset_source_model.sv
// Behavioural model of the external reset circuit driving the reset pin
`timescale 1ns/1ps
module reset_source_model (
   input wire logic sys_clk,
   input wire logic start,
   input wire logic [7:0] low_clocks,
   output logic reset_pin_n
);
   logic [7:0] cnt_q;
   initial begin
      cnt_q = 8'h00;
      reset_pin_n = 1'b1;
   end
   // Pin has a pull-up, so an idle source leaves it high; a pulse shorter
   // than two machine cycles is only made when the bench asks for it
   always @(posedge sys_clk) begin
      if (start) begin
         cnt_q <= low_clocks;
         reset_pin_n <= 1'b0;
      end else if (cnt_q > 8'h01) begin
         cnt_q <= cnt_q - 8'h01;
      end else begin
         cnt_q <= 8'h00;
         reset_pin_n <= 1'b1;
      end
   end
endmodule

// >>> tb/reset_sync_and_output_tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module reset_sync_and_output_tb_top;
   import reset_seq_pkg::*;
   logic sys_clk, rst_b, reset_pin_n, wdt_req, osc_req, ext_n, start, core_reset, reset_out_n;
   logic addr_drive, ale_first_fall, arith_control_msb;
   logic [7:0] low_clocks;
   logic [15:0] program_counter;
   logic [7:0] irq_enable_0, irq_enable_1, watchdog_reload, stack_pointer;
   logic [7:0] b_register, power_control, program_status_word, timer_control;
   logic [NUM_PORTS*8-1:0] port_latches;
   logic [PTR_SEL_WIDTH-1:0] pointer_select;
   logic [NUM_COMPARE*8-1:0] compare_low_bytes;
   logic [NUM_POINTERS*16-1:0] data_pointers;
   int fails, total_checks, ro_low, cr_high, cr_fall, addr_t, ale_t, ale_cnt;

   reset_source_model src_u (.sys_clk(sys_clk), .start(start), .low_clocks(low_clocks),
      .reset_pin_n(reset_pin_n));
   reset_sync_and_output dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reset_pin_n(reset_pin_n),
      .wdt_reset_req(wdt_req), .osc_wdt_reset_req(osc_req), .ext_program_select_n(ext_n),
      .core_reset(core_reset), .reset_out_n(reset_out_n), .addr_drive(addr_drive),
      .ale_first_fall(ale_first_fall), .program_counter(program_counter),
      .irq_enable_0(irq_enable_0), .irq_enable_1(irq_enable_1), .port_latches(port_latches),
      .arith_control_msb(arith_control_msb), .pointer_select(pointer_select),
      .watchdog_reload(watchdog_reload), .stack_pointer(stack_pointer),
      .compare_low_bytes(compare_low_bytes), .data_pointers(data_pointers),
      .b_register(b_register), .power_control(power_control),
      .program_status_word(program_status_word), .timer_control(timer_control));

   task automatic wrap_up();
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic check_defaults();
      chk(program_counter, PC_RESET);
      chk({irq_enable_0, irq_enable_1}, {IEN_RESET, IEN_RESET});
      chk(port_latches, {NUM_PORTS{PORT_RESET}});
      chk(arith_control_msb, 1'b0);
      chk(pointer_select, PTR_SEL_RESET);
      chk(watchdog_reload, WDT_RELOAD_RESET);
      chk(stack_pointer, SP_RESET);
      chk(compare_low_bytes, {NUM_COMPARE{ZERO_BYTE}});
      chk(data_pointers, {NUM_POINTERS{DPTR_RESET}});
      chk({b_register, power_control, program_status_word, timer_control}, 32'h00000000);
   endtask

   // Counts cycles of each output over a window, sampled mid-cycle
   task automatic observe(input int n);
      logic cr_prev, ad_prev;
      ro_low = 0; cr_high = 0; cr_fall = -1; addr_t = -1; ale_t = -1; ale_cnt = 0;
      cr_prev = core_reset;
      ad_prev = addr_drive;
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk);
         if (reset_out_n === 1'b0) ro_low++;
         if (core_reset === 1'b1) begin
            cr_high++;
            check_defaults();
         end
         if (cr_prev === 1'b1 && core_reset === 1'b0) cr_fall = i;
         if (ad_prev === 1'b0 && addr_drive === 1'b1) addr_t = i;
         if (ale_first_fall === 1'b1) begin
            ale_cnt++;
            ale_t = i;
         end
         cr_prev = core_reset;
         ad_prev = addr_drive;
      end
   endtask

   task automatic pin_pulse(input int len, input logic ext);
      @(posedge sys_clk);
      ext_n <= ext;
      start <= 1'b1;
      low_clocks <= len[7:0];
      @(posedge sys_clk);
      start <= 1'b0;
      observe(len + 60);
   endtask

   task automatic test_after_rst();
      observe(4);
      chk({reset_out_n, core_reset, addr_drive}, 3'b100);
      check_defaults();
   endtask

   task automatic test_ext_fetch();
      pin_pulse(30, 1'b0);
      chk(ro_low % 12 == 0 && ro_low >= 24 && ro_low <= 41, 1'b1);
      chk(cr_high, ro_low - 12);
      chk(addr_t - cr_fall, 11);
      chk({ale_cnt, ale_t}, {32'h00000001, addr_t + 1});
   endtask

   task automatic test_long_internal();
      pin_pulse(60, 1'b1);
      chk(ro_low, 60);
      chk(cr_high, 48);
      chk({addr_drive, ale_cnt}, {1'b0, 32'h00000000});
   endtask

   task automatic test_short_pulse();
      // Deliberately below the minimum width: one sample only
      pin_pulse(12, 1'b0);
      chk(ro_low, 12);
      chk(cr_high, 0);
   endtask

   task automatic test_watchdogs();
      for (int s = 0; s < 2; s++) begin
         @(posedge sys_clk);
         wdt_req <= (s == 0);
         osc_req <= (s == 1);
         @(posedge sys_clk);
         wdt_req <= 1'b0;
         osc_req <= 1'b0;
         observe(60);
         chk(ro_low >= 24 && ro_low <= 36, 1'b1);
         chk(reset_out_n, 1'b1);
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial begin
      rst_b = 1'b0;
      wdt_req = 1'b0;
      osc_req = 1'b0;
      ext_n = 1'b0;
      start = 1'b0;
      low_clocks = 8'h00;
      fails = 0;
      total_checks = 0;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      test_after_rst();
      test_ext_fetch();
      test_long_internal();
      test_short_pulse();
      test_watchdogs();
      wrap_up();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      wrap_up();
   end
endmodule
